// file: shared/tmr8_map.vh
`ifndef TMR8_MAP_VH
`define TMR8_MAP_VH

// register byte offsets on the avalon slave, one aligned word each
`define TMR8_OFS_CTRL_A      5'h00
`define TMR8_OFS_CTRL_B      5'h04
`define TMR8_OFS_COUNT       5'h08
`define TMR8_OFS_CMP_A       5'h0C
`define TMR8_OFS_CMP_B       5'h10
`define TMR8_OFS_MASK        5'h14
`define TMR8_OFS_FLAG        5'h18
`define TMR8_OFS_POWER       5'h1C

// control_reg_a fields
`define TMR8_CA_WGM_LSB      0
`define TMR8_CA_WGM_MSB      1
`define TMR8_CA_OUTB_LSB     4
`define TMR8_CA_OUTB_MSB     5
`define TMR8_CA_OUTA_LSB     6
`define TMR8_CA_OUTA_MSB     7

// control_reg_b fields
`define TMR8_CB_CS_LSB       0
`define TMR8_CB_CS_MSB       2
`define TMR8_CB_WGM2_BIT     3

// flag and mask bit positions
`define TMR8_BIT_OVF         0
`define TMR8_BIT_CMPA        1
`define TMR8_BIT_CMPB        2

// power register bit
`define TMR8_BIT_POWER_OFF   0

// reset values
`define TMR8_RST_BYTE        8'h00
`define TMR8_RST_FLAGS       3'h0

// count range limits
`define TMR8_BOTTOM          8'h00
`define TMR8_MAX             8'hFF

// waveform_mode encodings
`define TMR8_WGM_NORMAL      3'h0
`define TMR8_WGM_PHASE_MAX   3'h1
`define TMR8_WGM_CTC         3'h2
`define TMR8_WGM_FAST_MAX    3'h3
`define TMR8_WGM_PHASE_CMPA  3'h5
`define TMR8_WGM_FAST_CMPA   3'h7

// clock_select encodings
`define TMR8_CS_STOP         3'h0
`define TMR8_CS_DIV1         3'h1
`define TMR8_CS_DIV8         3'h2
`define TMR8_CS_DIV64        3'h3
`define TMR8_CS_DIV256       3'h4
`define TMR8_CS_DIV1024      3'h5
`define TMR8_CS_EXT_FALL     3'h6
`define TMR8_CS_EXT_RISE     3'h7

// prescaler tap masks: a tap fires when the low bits are all ones
`define TMR8_DIV8_MASK       10'h007
`define TMR8_DIV64_MASK      10'h03F
`define TMR8_DIV256_MASK     10'h0FF
`define TMR8_DIV1024_MASK    10'h3FF

`endif

// file: core/tmr8_cmp_unit.v
`timescale 1ns/1ps
`default_nettype none

// one compare channel: cpu-side buffer, active value and equality
module tmr8_cmp_unit #(
	parameter WIDTH = 8
) (
	input  wire             clk,       // system clock
	input  wire             rst_n,     // synchronous reset, active low
	input  wire             wr_en,     // cpu write strobe for this channel
	input  wire [WIDTH-1:0] wr_data,   // cpu write value
	input  wire             buffered,  // pwm mode, double buffering on
	input  wire             load,      // update point of the count sequence
	input  wire             tick,      // timer tick
	input  wire [WIDTH-1:0] count,     // current counter value
	output wire [WIDTH-1:0] shadow,    // value seen by cpu reads
	output wire [WIDTH-1:0] active,    // value used by the comparator
	output wire             eq,        // counter equals active value
	output wire             match      // equality seen on a tick
);

	reg [WIDTH-1:0] buf_reg;
	reg [WIDTH-1:0] act_reg;

	// in pwm modes the active value moves only at the update point, so
	// a mid-period write cannot give a short or asymmetric pulse
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			buf_reg <= {WIDTH{1'b0}};
			act_reg <= {WIDTH{1'b0}};
		end
		else
		begin
			if (wr_en)
				buf_reg <= wr_data;
			if (!buffered && wr_en)
				act_reg <= wr_data;
			else if (buffered && load)
				act_reg <= buf_reg;
		end
	end

	// comparator runs every cycle, the flag path samples it per tick
	assign shadow = buf_reg;
	assign active = act_reg;
	assign eq     = (count == act_reg);
	assign match  = tick & eq;

endmodule

`default_nettype wire

// file: core/tmr8_core.v
`timescale 1ns/1ps
`include "tmr8_map.vh"
`default_nettype none

module tmr8_core #(
	parameter WIDTH   = 8,
	parameter PRE_W   = 10
) (
	input  wire        clk,             // system clock, 200 mhz
	input  wire        rst_n,           // synchronous reset, active low
	input  wire [4:0]  avs_address,     // byte address
	input  wire        avs_read,        // read request
	input  wire        avs_write,       // write request
	input  wire [31:0] avs_writedata,   // write data
	input  wire [3:0]  avs_byteenable,  // byte lanes, lane 0 used
	output reg  [31:0] avs_readdata,    // read data
	output reg         avs_waitrequest, // stall, low marks the answer
	input  wire        ext_count_pin,   // external count input, async
	output reg         compare_out_a,   // waveform output a
	output reg         compare_out_b,   // waveform output b
	output reg         overflow_irq,    // masked overflow request
	output reg         compare_a_irq,   // masked compare a request
	output reg         compare_b_irq    // masked compare b request
);

	// counting direction states
	localparam DIR_UP   = 2'b01;
	localparam DIR_DOWN = 2'b10;

	// waveform generator kinds
	localparam KIND_PLAIN = 3'b001;
	localparam KIND_FAST  = 3'b010;
	localparam KIND_PHASE = 3'b100;

	reg  [WIDTH-1:0] ctrl_a_reg;
	reg  [WIDTH-1:0] ctrl_b_reg;
	reg  [WIDTH-1:0] counter_value;
	reg  [2:0]       mask_reg;
	reg  [2:0]       flag_reg;
	reg              power_off_reg;
	reg  [1:0]       dir_reg;
	reg  [PRE_W-1:0] pre_reg;
	reg              ext_meta_reg;
	reg              ext_sync_reg;
	reg              ext_prev_reg;

	reg  [WIDTH-1:0] cnt_next;
	reg  [1:0]       dir_next;
	reg  [WIDTH-1:0] top_value;
	reg  [2:0]       kind;
	reg              tick_raw;
	reg  [31:0]      rd_mux;
	reg  [2:0]       flag_next;

	wire             bus_req;
	wire             wr_fire;
	wire             wr_byte;
	wire [WIDTH-1:0] wr_val;
	wire             cnt_wr;
	wire [2:0]       wave_mode;
	wire [2:0]       clock_select;
	wire             timer_tick;
	wire             at_top;
	wire             at_bottom;
	wire             buffered;
	wire             load_pt;
	wire             ovf_evt;
	wire [WIDTH-1:0] cmp_a_shadow;
	wire [WIDTH-1:0] cmp_a_active;
	wire [WIDTH-1:0] cmp_b_shadow;
	wire             match_a;
	wire             match_b;

	// bus handshake: a request is taken while waitrequest is high, the
	// answer comes one edge later with waitrequest low for one cycle
	assign bus_req = (avs_read | avs_write) & avs_waitrequest;
	assign wr_fire = avs_write & ~avs_waitrequest;
	assign wr_byte = wr_fire & avs_byteenable[0];
	assign wr_val  = avs_writedata[WIDTH-1:0];
	assign cnt_wr  = wr_byte & (avs_address == `TMR8_OFS_COUNT);

	// mode and source fields
	assign wave_mode    = {ctrl_b_reg[`TMR8_CB_WGM2_BIT],
	                       ctrl_a_reg[`TMR8_CA_WGM_MSB:`TMR8_CA_WGM_LSB]};
	assign clock_select = ctrl_b_reg[`TMR8_CB_CS_MSB:`TMR8_CB_CS_LSB];

	// handshake and read data register
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end
		else if (bus_req)
		begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_mux;
		end
		else
		begin
			avs_waitrequest <= 1'b1;
		end
	end

	// read decode; unmapped or unaligned addresses read as zero
	always @*
	begin
		rd_mux = 32'h00000000;
		case (avs_address)
			`TMR8_OFS_CTRL_A: rd_mux[WIDTH-1:0] = ctrl_a_reg;
			`TMR8_OFS_CTRL_B: rd_mux[WIDTH-1:0] = ctrl_b_reg;
			`TMR8_OFS_COUNT:  rd_mux[WIDTH-1:0] = counter_value;
			`TMR8_OFS_CMP_A:  rd_mux[WIDTH-1:0] = cmp_a_shadow;
			`TMR8_OFS_CMP_B:  rd_mux[WIDTH-1:0] = cmp_b_shadow;
			`TMR8_OFS_MASK:   rd_mux[2:0]       = mask_reg;
			`TMR8_OFS_FLAG:   rd_mux[2:0]       = flag_reg;
			`TMR8_OFS_POWER:  rd_mux[0]         = power_off_reg;
			default:          rd_mux            = 32'h00000000;
		endcase
	end

	// configuration registers, all zero after reset
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_a_reg    <= `TMR8_RST_BYTE;
			ctrl_b_reg    <= `TMR8_RST_BYTE;
			mask_reg      <= `TMR8_RST_FLAGS;
			power_off_reg <= 1'b0;
		end
		else if (wr_byte)
		begin
			case (avs_address)
				`TMR8_OFS_CTRL_A: ctrl_a_reg    <= wr_val;
				`TMR8_OFS_CTRL_B: ctrl_b_reg    <= wr_val;
				`TMR8_OFS_MASK:   mask_reg      <= wr_val[2:0];
				`TMR8_OFS_POWER:  power_off_reg <= wr_val[`TMR8_BIT_POWER_OFF];
				default:          power_off_reg <= power_off_reg;
			endcase
		end
	end

	// free-running prescaler, shared by every divided tap
	always @(posedge clk)
	begin
		if (!rst_n)
			pre_reg <= {PRE_W{1'b0}};
		else
			pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
	end

	// external pin: two flops to resynchronise, a third for edge detect
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end
		else
		begin
			ext_meta_reg <= ext_count_pin;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
		end
	end

	// tick source select; the pin path costs about three clocks of delay
	always @*
	begin
		case (clock_select)
			`TMR8_CS_STOP:     tick_raw = 1'b0;
			`TMR8_CS_DIV1:     tick_raw = 1'b1;
			`TMR8_CS_DIV8:     tick_raw = &(pre_reg | ~`TMR8_DIV8_MASK);
			`TMR8_CS_DIV64:    tick_raw = &(pre_reg | ~`TMR8_DIV64_MASK);
			`TMR8_CS_DIV256:   tick_raw = &(pre_reg | ~`TMR8_DIV256_MASK);
			`TMR8_CS_DIV1024:  tick_raw = &(pre_reg | ~`TMR8_DIV1024_MASK);
			`TMR8_CS_EXT_FALL: tick_raw = ext_prev_reg & ~ext_sync_reg;
			`TMR8_CS_EXT_RISE: tick_raw = ~ext_prev_reg & ext_sync_reg;
			default:           tick_raw = 1'b0;
		endcase
	end

	// a powered-off timer sees no ticks but keeps its registers
	assign timer_tick = tick_raw & ~power_off_reg;

	// mode decode: top value and waveform kind; reserved modes act normal
	always @*
	begin
		top_value = `TMR8_MAX;
		kind      = KIND_PLAIN;
		case (wave_mode)
			`TMR8_WGM_PHASE_MAX:  kind = KIND_PHASE;
			`TMR8_WGM_CTC:        top_value = cmp_a_active;
			`TMR8_WGM_FAST_MAX:   kind = KIND_FAST;
			`TMR8_WGM_PHASE_CMPA:
			begin
				kind      = KIND_PHASE;
				top_value = cmp_a_active;
			end
			`TMR8_WGM_FAST_CMPA:
			begin
				kind      = KIND_FAST;
				top_value = cmp_a_active;
			end
			default:              kind = KIND_PLAIN;
		endcase
	end

	// boundary indications
	assign at_top    = (counter_value == top_value);
	assign at_bottom = (counter_value == `TMR8_BOTTOM);
	assign buffered  = (kind != KIND_PLAIN);
	assign load_pt   = timer_tick & at_top;

	// next count: up/clear for single slope, up/down for dual slope
	always @*
	begin
		cnt_next = counter_value;
		dir_next = dir_reg;
		if (timer_tick)
		begin
			case (kind)
				KIND_PHASE:
				begin
					case (dir_reg)
						DIR_UP:
						begin
							if (at_top)
							begin
								dir_next = DIR_DOWN;
								cnt_next = at_bottom ? `TMR8_BOTTOM :
								           counter_value - 8'h01;
							end
							else
								cnt_next = counter_value + 8'h01;
						end
						DIR_DOWN:
						begin
							if (at_bottom)
							begin
								dir_next = DIR_UP;
								cnt_next = at_top ? `TMR8_BOTTOM :
								           counter_value + 8'h01;
							end
							else
								cnt_next = counter_value - 8'h01;
						end
						default:
						begin
							dir_next = DIR_UP;
							cnt_next = counter_value;
						end
					endcase
				end
				default:
				begin
					// single slope: clear at top, else up; 8-bit add wraps
					dir_next = DIR_UP;
					if (at_top)
						cnt_next = `TMR8_BOTTOM;
					else
						cnt_next = counter_value + 8'h01;
				end
			endcase
		end
		if (cnt_wr)
			cnt_next = wr_val;
	end

	// counter and direction state
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			counter_value <= `TMR8_RST_BYTE;
			dir_reg       <= DIR_UP;
		end
		else
		begin
			counter_value <= cnt_next;
			dir_reg       <= dir_next;
		end
	end

	// overflow point: wrap past max when plain, top when fast, bottom
	// when dual slope; a cpu counter write cancels the overflow of that tick, not its compare matches
	assign ovf_evt = timer_tick & ~cnt_wr &
	                 (((kind == KIND_PLAIN) && (counter_value == `TMR8_MAX)) ||
	                  ((kind == KIND_FAST) && at_top) ||
	                  ((kind == KIND_PHASE) && at_bottom &&
	                   (dir_reg == DIR_DOWN)));

	// compare channels
	tmr8_cmp_unit #(
		.WIDTH    (WIDTH)
	) u_cmp_a (
		.clk      (clk),
		.rst_n    (rst_n),
		.wr_en    (wr_byte & (avs_address == `TMR8_OFS_CMP_A)),
		.wr_data  (wr_val),
		.buffered (buffered),
		.load     (load_pt),
		.tick     (timer_tick),
		.count    (counter_value),
		.shadow   (cmp_a_shadow),
		.active   (cmp_a_active),
		.eq       (),
		.match    (match_a)
	);

	tmr8_cmp_unit #(
		.WIDTH    (WIDTH)
	) u_cmp_b (
		.clk      (clk),
		.rst_n    (rst_n),
		.wr_en    (wr_byte & (avs_address == `TMR8_OFS_CMP_B)),
		.wr_data  (wr_val),
		.buffered (buffered),
		.load     (load_pt),
		.tick     (timer_tick),
		.count    (counter_value),
		.shadow   (cmp_b_shadow),
		.active   (),
		.eq       (),
		.match    (match_b)
	);

	// flags clear on write-one; a same-cycle event still sets the bit
	always @*
	begin
		flag_next = flag_reg;
		if (wr_byte && (avs_address == `TMR8_OFS_FLAG))
			flag_next = flag_reg & ~wr_val[2:0];
		flag_next[`TMR8_BIT_OVF]  = flag_next[`TMR8_BIT_OVF] | ovf_evt;
		flag_next[`TMR8_BIT_CMPA] = flag_next[`TMR8_BIT_CMPA] | match_a;
		flag_next[`TMR8_BIT_CMPB] = flag_next[`TMR8_BIT_CMPB] | match_b;
	end

	// flag register and masked requests
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			flag_reg      <= `TMR8_RST_FLAGS;
			overflow_irq  <= 1'b0;
			compare_a_irq <= 1'b0;
			compare_b_irq <= 1'b0;
		end
		else
		begin
			flag_reg      <= flag_next;
			overflow_irq  <= flag_next[`TMR8_BIT_OVF] & mask_reg[`TMR8_BIT_OVF];
			compare_a_irq <= flag_next[`TMR8_BIT_CMPA] & mask_reg[`TMR8_BIT_CMPA];
			compare_b_irq <= flag_next[`TMR8_BIT_CMPB] & mask_reg[`TMR8_BIT_CMPB];
		end
	end

	// waveform step: plain modes toggle/clear/set on match; pwm modes
	// use action 2 as non-inverting and 3 as inverting, 0 and 1 hold
	function wave_step;
		input       cur;
		input [1:0] act;
		input       match;
		input       wrap;
		input       up;
		input [2:0] knd;
		begin
			wave_step = cur;
			case (knd)
				KIND_FAST:
				begin
					if (act[1] && match)
						wave_step = act[0];
					else if (act[1] && wrap)
						wave_step = ~act[0];
				end
				KIND_PHASE:
				begin
					if (act[1] && match)
						wave_step = up ? act[0] : ~act[0];
				end
				default:
				begin
					if (match)
					begin
						case (act)
							2'h1:    wave_step = ~cur;
							2'h2:    wave_step = 1'b0;
							2'h3:    wave_step = 1'b1;
							default: wave_step = cur;
						endcase
					end
				end
			endcase
		end
	endfunction

	// output flops; they keep their level across mode changes
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			compare_out_a <= 1'b0;
			compare_out_b <= 1'b0;
		end
		else
		begin
			compare_out_a <= wave_step(compare_out_a,
			                           ctrl_a_reg[`TMR8_CA_OUTA_MSB:`TMR8_CA_OUTA_LSB],
			                           match_a, load_pt, dir_reg == DIR_UP,
			                           kind);
			compare_out_b <= wave_step(compare_out_b,
			                           ctrl_a_reg[`TMR8_CA_OUTB_MSB:`TMR8_CA_OUTB_LSB],
			                           match_b, load_pt, dir_reg == DIR_UP,
			                           kind);
		end
	end

endmodule

`default_nettype wire

// file: dv/tmr8_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_map.vh"
// watches the register bus and the interrupt levels of the timer core
module tmr8_core_chk (
	input wire logic        clk,             // system clock
	input wire logic        rst_n,           // sync reset, low
	input wire logic [4:0]  avs_address,     // byte address
	input wire logic        avs_read,        // read request
	input wire logic        avs_write,       // write request
	input wire logic [31:0] avs_writedata,   // write data
	input wire logic [3:0]  avs_byteenable,  // byte lanes
	input wire logic [31:0] avs_readdata,    // read data
	input wire logic        avs_waitrequest, // stall
	input wire logic        overflow_irq,    // overflow level
	input wire logic        compare_a_irq,   // compare a level
	input wire logic        compare_b_irq    // compare b level
);
	// one clock domain, so one clocking and one reset guard for all
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_short: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("answer stood longer than one cycle");
	// an idle bus must not disturb the last read value
	a_idle_hold: assert property (
		avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest && $stable(avs_readdata))
		else $error("idle bus changed wait or read data");
	a_reset_quiet: assert property (
		$rose(rst_n) |-> avs_waitrequest && avs_readdata == 32'h00000000
			&& !overflow_irq && !compare_a_irq && !compare_b_irq)
		else $error("outputs not quiet after reset");
	a_upper_zero: assert property (
		!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("read data wider than eight bits");
	a_flag_width: assert property (
		avs_read && !avs_waitrequest && (avs_address == `TMR8_OFS_MASK
			|| avs_address == `TMR8_OFS_FLAG) |-> avs_readdata[31:3] == 29'h00000000)
		else $error("mask or flag read has more than three bits");
	a_unmapped_zero: assert property (
		avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h00000000)
		else $error("unaligned read returned data");
	// a cleared mask must silence every request whatever the flags hold
	a_mask_gates: assert property (
		avs_write && !avs_waitrequest && avs_address == `TMR8_OFS_MASK && avs_byteenable[0]
			&& avs_writedata[2:0] == 3'h0 |-> ##2 !overflow_irq && !compare_a_irq && !compare_b_irq)
		else $error("interrupt level while masked");
endmodule
`default_nettype wire

// file: dv/tmr8_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu side of the timer: avalon master plus the external count source
module tmr8_cpu_model (
	input  wire logic        clk,             // system clock
	input  wire logic [31:0] avs_readdata,    // read data
	input  wire logic        avs_waitrequest, // stall
	output var  logic [4:0]  avs_address,     // byte address
	output var  logic        avs_read,        // read request
	output var  logic        avs_write,       // write request
	output var  logic [31:0] avs_writedata,   // write data
	output var  logic [3:0]  avs_byteenable,  // byte lanes
	output var  logic        ext_count_pin    // count pin
);
	// idle bus; the pin rests low so its first edge is a rise
	initial
	begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		ext_count_pin = 1'b0;
	end

	// a write with chosen lanes, held until waitrequest is sampled low; the upper
	// lanes carry junk the core must ignore, and stale data is inverted afterwards
	task automatic wrb(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {~d, ~d, ~d, d};
		avs_byteenable <= be;
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		avs_write <= 1'b0;
		avs_writedata <= ~avs_writedata;
	endtask

	// a plain write on all lanes
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		wrb(a, d, 4'hF);
	endtask

	// a read, data taken at the edge that sees waitrequest low
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	// pin levels stand six cycles, well past the synchroniser delay
	task automatic pin(input logic v);
		@(posedge clk);
		ext_count_pin <= v;
		repeat (6) @(posedge clk);
	endtask

	task automatic pulse(input int n);
		repeat (n)
		begin
			pin(1'b1);
			pin(1'b0);
		end
	endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr8_map.vh"
module tb;
	logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, ext_count_pin;
	logic        compare_out_a, compare_out_b, overflow_irq, compare_a_irq, compare_b_irq;
	logic [4:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd_val;
	logic [27:0] rows [28];
	int          mismatches, n_compared, cycles;

	// 200 mhz clock
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	tmr8_core dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_count_pin(ext_count_pin), .compare_out_a(compare_out_a),
		.compare_out_b(compare_out_b), .overflow_irq(overflow_irq),
		.compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq));
	tmr8_cpu_model cpu (.clk(clk), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .ext_count_pin(ext_count_pin));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] d;
		cpu.rd(a, d);
		chk(d, {24'h000000, e});
	endtask

	// levels are looked at once the edge's updates have landed
	task automatic irqs(input logic [2:0] e);
		#1;
		chk({29'h00000000, overflow_irq, compare_a_irq, compare_b_irq}, {29'h00000000, e});
	endtask

	// whole run is well under a thousand cycles; a hang ends here
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	initial
	begin
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		rst_n = 1'b0;
		// rows: write flags (bit 1 drops byte lane 0), offset, write data, expected read back
		rows = '{28'h0_00_00_00, 28'h0_04_00_00, 28'h0_08_00_00, 28'h0_0C_00_00,
			28'h0_10_00_00, 28'h0_14_00_00, 28'h0_18_00_00, 28'h0_1C_00_00,
			28'h1_00_F1_F1, 28'h1_04_08_08, 28'h1_08_A5_A5, 28'h1_0C_5A_5A,
			28'h1_10_C3_C3, 28'h1_14_FF_07, 28'h1_18_07_00, 28'h1_1C_03_01,
			28'h1_1E_FF_00, 28'h0_09_00_00, 28'h0_08_00_A5, 28'h1_1C_00_00,
			28'h1_04_00_00, 28'h1_00_40_40, 28'h1_0C_FF_FF, 28'h1_10_00_00,
			28'h1_08_FE_FE, 28'h3_08_11_FE, 28'h1_14_07_07, 28'h1_04_07_07};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			if (rows[i][24])
				cpu.wrb(rows[i][20:16], rows[i][15:8], rows[i][25] ? 4'hE : 4'h1);
			rdc(rows[i][20:16], rows[i][7:0]);
		end
		// mode 0 on rising pin edges, compare a at max, compare b at bottom
		cpu.pulse(1);
		rdc(`TMR8_OFS_COUNT, 8'hFF);
		irqs(3'h0);
		cpu.pulse(1);
		rdc(`TMR8_OFS_COUNT, 8'h00);
		irqs(3'h6);
		chk({31'h00000000, compare_out_a}, 32'h00000001);
		cpu.pulse(1);
		rdc(`TMR8_OFS_COUNT, 8'h01);
		irqs(3'h7);
		rdc(`TMR8_OFS_FLAG, 8'h07);
		cpu.wr(`TMR8_OFS_FLAG, 8'h07);
		rdc(`TMR8_OFS_FLAG, 8'h00);
		// falling edge select: a rise alone must not count
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h06);
		cpu.pin(1'b1);
		rdc(`TMR8_OFS_COUNT, 8'h01);
		cpu.pin(1'b0);
		rdc(`TMR8_OFS_COUNT, 8'h02);
		// flag still sets while masked, request only once unmasked
		cpu.wr(`TMR8_OFS_MASK, 8'h00);
		cpu.wr(`TMR8_OFS_COUNT, 8'h00);
		cpu.pulse(1);
		rdc(`TMR8_OFS_FLAG, 8'h04);
		irqs(3'h0);
		cpu.wr(`TMR8_OFS_MASK, 8'h04);
		rdc(`TMR8_OFS_FLAG, 8'h04);
		irqs(3'h1);
		// clear on compare a: top comes from compare a, no overflow
		cpu.wr(`TMR8_OFS_FLAG, 8'h07);
		cpu.wr(`TMR8_OFS_CTRL_A, 8'h02);
		cpu.wr(`TMR8_OFS_CMP_A, 8'h02);
		cpu.wr(`TMR8_OFS_COUNT, 8'h00);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h07);
		cpu.pulse(3);
		rdc(`TMR8_OFS_COUNT, 8'h00);
		rdc(`TMR8_OFS_FLAG, 8'h06);
		// phase mode turns round at max and counts down
		cpu.wr(`TMR8_OFS_FLAG, 8'h07);
		cpu.wr(`TMR8_OFS_CTRL_A, 8'h01);
		cpu.wr(`TMR8_OFS_COUNT, 8'hFE);
		cpu.pulse(2);
		rdc(`TMR8_OFS_COUNT, 8'hFE);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h00);
		cpu.pulse(1);
		rdc(`TMR8_OFS_COUNT, 8'hFE);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h07);
		cpu.wr(`TMR8_OFS_POWER, 8'h01);
		cpu.pulse(1);
		rdc(`TMR8_OFS_COUNT, 8'hFE);
		// second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdc(`TMR8_OFS_COUNT, 8'h00);
		rdc(`TMR8_OFS_CTRL_B, 8'h00);
		rdc(`TMR8_OFS_POWER, 8'h00);
		// a counter write during a full-rate tick wins; one tick lands before the read
		cpu.wr(`TMR8_OFS_COUNT, 8'h10);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h01);
		cpu.wr(`TMR8_OFS_COUNT, 8'h80);
		rdc(`TMR8_OFS_COUNT, 8'h81);
		// divide by 8 over 67 enabled clocks: 8 or 9 ticks, prescaler phase unknown
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h00);
		cpu.wr(`TMR8_OFS_COUNT, 8'h00);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h02);
		repeat (64) @(posedge clk);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h00);
		cpu.rd(`TMR8_OFS_COUNT, rd_val);
		chk({31'h00000000, rd_val == 32'h8 || rd_val == 32'h9}, 32'h00000001);
		// fast pwm: compare b waits for top, output b sets at top, clears on match
		cpu.wr(`TMR8_OFS_FLAG, 8'h07);
		cpu.wr(`TMR8_OFS_CTRL_A, 8'h23);
		cpu.wr(`TMR8_OFS_CMP_B, 8'h03);
		cpu.wr(`TMR8_OFS_COUNT, 8'h00);
		cpu.wr(`TMR8_OFS_CTRL_B, 8'h07);
		cpu.pulse(1);
		rdc(`TMR8_OFS_FLAG, 8'h06);
		cpu.wr(`TMR8_OFS_FLAG, 8'h07);
		cpu.wr(`TMR8_OFS_COUNT, 8'hFF);
		cpu.pulse(1);
		chk({31'h00000000, compare_out_b}, 32'h00000001);
		rdc(`TMR8_OFS_FLAG, 8'h01);
		cpu.pulse(4);
		chk({31'h00000000, compare_out_b}, 32'h00000000);
		rdc(`TMR8_OFS_FLAG, 8'h07);
		close_out();
	end
endmodule

bind tmr8_core tmr8_core_chk chk_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .overflow_irq(overflow_irq),
	.compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq));
`default_nettype wire
